// File: include/flash_host_pkg.sv
// flash host package: command codes, timing counts, carriers
// assumes a 20 MHz clock and an x16 asynchronous flash
package flash_host_pkg;

    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned CLK_HZ = 20_000_000;

    // minimum enable high time between polling reads
    localparam int unsigned ENABLE_HIGH_PULSE_MIN_NS = 50;
    localparam int unsigned ENABLE_HIGH_CYC =
        (ENABLE_HIGH_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // bus cycle phases, in clocks
    localparam int unsigned STROBE_CYC = 2;
    localparam int unsigned SETUP_CYC = 1;

    localparam int unsigned WORD_PROGRAM_DURATION_US = 120;
    localparam int unsigned DUAL_WORD_PROGRAM_DURATION_US = 60;
    localparam int unsigned SMALL_SECTOR_ERASE_MS = 2000;
    localparam int unsigned LARGE_SECTOR_ERASE_MS = 6000;
    localparam int unsigned CHIP_ERASE_TYP_S = 33;
    // chip erase timeout is twice the typical duration
    localparam int unsigned CHIP_ERASE_MARGIN = 2;

    localparam longint unsigned WORD_PROGRAM_CYC =
        longint'(WORD_PROGRAM_DURATION_US) * CLK_HZ / 1_000_000;
    localparam longint unsigned DUAL_PROGRAM_CYC =
        longint'(DUAL_WORD_PROGRAM_DURATION_US) * CLK_HZ / 1_000_000;
    localparam longint unsigned SMALL_ERASE_CYC =
        longint'(SMALL_SECTOR_ERASE_MS) * CLK_HZ / 1_000;
    localparam longint unsigned LARGE_ERASE_CYC =
        longint'(LARGE_SECTOR_ERASE_MS) * CLK_HZ / 1_000;
    localparam longint unsigned CHIP_ERASE_CYC =
        longint'(CHIP_ERASE_TYP_S) * CHIP_ERASE_MARGIN * CLK_HZ;

    localparam int unsigned ADDR_W = 21;
    localparam int unsigned DATA_W = 16;

    // command addresses decode only the low 12 bits
    localparam logic [11:0] UNLOCK_ADDR_1 = 12'h555;
    localparam logic [11:0] UNLOCK_ADDR_2 = 12'hAAA;
    localparam logic [7:0] UNLOCK_DATA_1 = 8'hAA;
    localparam logic [7:0] UNLOCK_DATA_2 = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_DUAL_PROGRAM = 8'hD0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [11:0] QUERY_ADDR = 12'h055;

    localparam int unsigned TOGGLE_BIT = 6;

    typedef enum logic [2:0] {
        OP_READ,
        OP_PROGRAM,
        OP_DUAL_PROGRAM,
        OP_SMALL_ERASE,
        OP_LARGE_ERASE,
        OP_CHIP_ERASE,
        OP_ID_ENTRY,
        OP_ID_EXIT
    } op_e;

    typedef struct packed {
        op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } req_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } pins_s;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic timeout;
    } resp_s;

endpackage

// File: design/flash_bus_cycle.sv
// one flash read or write cycle on the ce/oe/we strobes
// assumes flash inputs synchronous to sys_clk; one cycle at a time
`timescale 1ns/10ps
module flash_bus_cycle
    import flash_host_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic is_write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] dq_in,
    output pins_s pins,
    output logic [DATA_W-1:0] rdata,
    output logic done
);
    typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_RECOVER} cyc_e;

    cyc_e st_q, st_d;
    logic [2:0] cnt_q, cnt_d;
    pins_s pins_q, pins_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic done_q, done_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        pins_d = pins_q;
        rdata_d = rdata_q;
        done_d = 1'b0;
        case (st_q)
            C_IDLE: begin
                if (start) begin
                    // address held stable through the whole cycle
                    pins_d.addr = addr;
                    pins_d.dq_out = wdata;
                    pins_d.dq_oe = is_write;
                    pins_d.oe_n = 1'b1;
                    cnt_d = 3'(SETUP_CYC);
                    st_d = C_SETUP;
                end
            end
            C_SETUP: begin
                if (cnt_q > 3'd1) begin
                    cnt_d = cnt_q - 3'd1;
                end else begin
                    pins_d.ce_n = 1'b0;
                    pins_d.we_n = !pins_q.dq_oe;
                    pins_d.oe_n = pins_q.dq_oe;
                    cnt_d = 3'(STROBE_CYC);
                    st_d = C_STROBE;
                end
            end
            C_STROBE: begin
                if (cnt_q > 3'd1) begin
                    cnt_d = cnt_q - 3'd1;
                end else begin
                    rdata_d = dq_in;
                    pins_d.ce_n = 1'b1;
                    pins_d.we_n = 1'b1;
                    pins_d.oe_n = 1'b1;
                    cnt_d = 3'(ENABLE_HIGH_CYC);
                    st_d = C_RECOVER;
                end
            end
            C_RECOVER: begin
                // minimum enable high time before the next access
                if (cnt_q > 3'd1) begin
                    cnt_d = cnt_q - 3'd1;
                end else begin
                    pins_d.dq_oe = 1'b0;
                    done_d = 1'b1;
                    st_d = C_IDLE;
                end
            end
            default: st_d = C_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= C_IDLE;
            cnt_q <= 3'h0;
            pins_q <= '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            rdata_q <= '0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            pins_q <= pins_d;
            rdata_q <= rdata_d;
            done_q <= done_d;
        end
    end

    assign pins = pins_q;
    assign rdata = rdata_q;
    assign done = done_q;
endmodule

// File: design/flash_host_ctrl.sv
// issues flash command sequences and polls for completion
// assumes x16 flash pins synchronous to sys_clk; dq split into in, out and enable
`timescale 1ns/10ps

module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter longint unsigned PROGRAM_TIMEOUT = WORD_PROGRAM_CYC,
    parameter longint unsigned DUAL_TIMEOUT = DUAL_PROGRAM_CYC,
    parameter longint unsigned SMALL_ERASE_TIMEOUT = SMALL_ERASE_CYC,
    parameter longint unsigned LARGE_ERASE_TIMEOUT = LARGE_ERASE_CYC,
    parameter longint unsigned CHIP_ERASE_TIMEOUT = CHIP_ERASE_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req_valid,
    input req_s req,
    output logic req_ready,
    output logic resp_valid,
    output resp_s resp,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [DATA_W-1:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [DATA_W-1:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n
);
    localparam int TW = 32;

    if (PROGRAM_TIMEOUT == 0 || DUAL_TIMEOUT == 0 || SMALL_ERASE_TIMEOUT == 0 ||
        LARGE_ERASE_TIMEOUT == 0 || CHIP_ERASE_TIMEOUT == 0 ||
        CHIP_ERASE_TIMEOUT >= (64'd1 << TW)) begin : g_bad_timeout
        $error("timeout parameter out of range");
    end

    typedef enum logic [2:0] {S_IDLE, S_SEQ, S_WAIT, S_POLL, S_POLL_WAIT, S_RESP} st_e;

    st_e st_q, st_d;
    req_s cur_q, cur_d;
    logic [2:0] step_q, step_d;
    logic [TW-1:0] tmo_q, tmo_d;
    logic first_q, first_d;
    logic tog_q, tog_d;
    logic resp_valid_q, resp_valid_d;
    resp_s resp_q, resp_d;
    logic ready_q, ready_d;

    logic cyc_start;
    logic cyc_write;
    logic [ADDR_W-1:0] cyc_addr;
    logic [DATA_W-1:0] cyc_wdata;
    pins_s pins;
    logic [DATA_W-1:0] cyc_rdata;
    logic cyc_done;

    flash_bus_cycle u_cycle (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(cyc_start),
        .is_write(cyc_write),
        .addr(cyc_addr),
        .wdata(cyc_wdata),
        .dq_in(flash_dq_in),
        .pins(pins),
        .rdata(cyc_rdata),
        .done(cyc_done)
    );

    // command cycle table; the flash ignores high address and data bits
    function automatic logic [ADDR_W+8:0] seq_entry(input op_e op, input logic [2:0] step,
                                                     input logic [ADDR_W-1:0] a,
                                                     input logic [7:0] d);
        logic [ADDR_W-1:0] ca;
        logic [7:0] cd;
        logic last;
        ca = {{(ADDR_W-12){1'b0}}, UNLOCK_ADDR_1};
        cd = 8'h00;
        last = 1'b0;
        case (step)
            3'd0: cd = UNLOCK_DATA_1;
            3'd1: begin
                ca = {{(ADDR_W-12){1'b0}}, UNLOCK_ADDR_2};
                cd = UNLOCK_DATA_2;
            end
            3'd2: begin
                case (op)
                    OP_PROGRAM: cd = CMD_PROGRAM;
                    OP_DUAL_PROGRAM: cd = CMD_DUAL_PROGRAM;
                    OP_ID_ENTRY: begin
                        cd = CMD_ID_ENTRY;
                        last = 1'b1;
                    end
                    OP_ID_EXIT: begin
                        cd = CMD_ID_EXIT;
                        last = 1'b1;
                    end
                    default: cd = CMD_ERASE_SETUP;
                endcase
            end
            3'd3: begin
                if (op == OP_PROGRAM || op == OP_DUAL_PROGRAM) begin
                    ca = a;
                    cd = d;
                    last = 1'b1;
                end else begin
                    cd = UNLOCK_DATA_1;
                end
            end
            3'd4: begin
                ca = {{(ADDR_W-12){1'b0}}, UNLOCK_ADDR_2};
                cd = UNLOCK_DATA_2;
            end
            default: begin
                last = 1'b1;
                if (op == OP_CHIP_ERASE) begin
                    cd = CMD_CHIP_ERASE;
                end else begin
                    ca = a;
                    cd = CMD_SECTOR_ERASE;
                end
            end
        endcase
        return {last, ca, cd};
    endfunction

    logic [ADDR_W+8:0] ent;
    logic ent_last;
    logic [ADDR_W-1:0] ent_addr;
    logic [7:0] ent_data;

    always_comb begin
        ent = seq_entry(cur_q.op, step_q, cur_q.addr, cur_q.data[7:0]);
        ent_last = ent[ADDR_W+8];
        ent_addr = ent[ADDR_W+7:8];
        ent_data = ent[7:0];
    end

    function automatic logic [TW-1:0] timeout_for(input op_e op);
        case (op)
            OP_PROGRAM: return TW'(PROGRAM_TIMEOUT);
            OP_DUAL_PROGRAM: return TW'(DUAL_TIMEOUT);
            OP_SMALL_ERASE: return TW'(SMALL_ERASE_TIMEOUT);
            OP_LARGE_ERASE: return TW'(LARGE_ERASE_TIMEOUT);
            OP_CHIP_ERASE: return TW'(CHIP_ERASE_TIMEOUT);
            default: return TW'(1);
        endcase
    endfunction

    always_comb begin
        st_d = st_q;
        cur_d = cur_q;
        step_d = step_q;
        tmo_d = tmo_q;
        first_d = first_q;
        tog_d = tog_q;
        resp_valid_d = 1'b0;
        resp_d = resp_q;
        ready_d = 1'b0;
        cyc_start = 1'b0;
        cyc_write = 1'b0;
        cyc_addr = cur_q.addr;
        cyc_wdata = '0;
        if (tmo_q != '0 && (st_q == S_POLL || st_q == S_POLL_WAIT)) begin
            tmo_d = tmo_q - TW'(1);
        end
        case (st_q)
            S_IDLE: begin
                ready_d = 1'b1;
                if (req_valid && ready_q) begin
                    ready_d = 1'b0;
                    cur_d = req;
                    step_d = 3'd0;
                    resp_d = '0;
                    st_d = (req.op == OP_READ) ? S_POLL : S_SEQ;
                    first_d = 1'b1;
                end
            end
            S_SEQ: begin
                cyc_start = 1'b1;
                cyc_write = 1'b1;
                cyc_addr = ent_addr;
                cyc_wdata = {8'h00, ent_data};
                st_d = S_WAIT;
            end
            S_WAIT: begin
                if (cyc_done) begin
                    if (!ent_last) begin
                        step_d = step_q + 3'd1;
                        st_d = S_SEQ;
                    end else if (cur_q.op == OP_ID_ENTRY || cur_q.op == OP_ID_EXIT) begin
                        st_d = S_RESP;
                    end else begin
                        tmo_d = timeout_for(cur_q.op);
                        first_d = 1'b1;
                        st_d = S_POLL;
                    end
                end
            end
            S_POLL: begin
                cyc_start = 1'b1;
                cyc_addr = cur_q.addr;
                st_d = S_POLL_WAIT;
            end
            S_POLL_WAIT: begin
                if (cyc_done) begin
                    resp_d.rdata = cyc_rdata;
                    tog_d = cyc_rdata[TOGGLE_BIT];
                    if (cur_q.op == OP_READ) begin
                        st_d = S_RESP;
                    end else if (!first_q && tog_q == cyc_rdata[TOGGLE_BIT]) begin
                        // toggle bit equal in two reads in a row: done
                        st_d = S_RESP;
                    end else if (tmo_q == '0) begin
                        resp_d.timeout = 1'b1;
                        st_d = S_RESP;
                    end else begin
                        first_d = 1'b0;
                        st_d = S_POLL;
                    end
                end
            end
            S_RESP: begin
                resp_valid_d = 1'b1;
                st_d = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= S_IDLE;
            cur_q <= '0;
            step_q <= 3'h0;
            tmo_q <= '0;
            first_q <= 1'b1;
            tog_q <= 1'b0;
            resp_valid_q <= 1'b0;
            resp_q <= '0;
            ready_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cur_q <= cur_d;
            step_q <= step_d;
            tmo_q <= tmo_d;
            first_q <= first_d;
            tog_q <= tog_d;
            resp_valid_q <= resp_valid_d;
            resp_q <= resp_d;
            ready_q <= ready_d;
        end
    end

    assign req_ready = ready_q;
    assign resp_valid = resp_valid_q;
    assign resp = resp_q;
    assign flash_addr = pins.addr;
    assign flash_dq_out = pins.dq_out;
    assign flash_dq_oe = pins.dq_oe;
    assign flash_ce_n = pins.ce_n;
    assign flash_oe_n = pins.oe_n;
    assign flash_we_n = pins.we_n;
endmodule

// File: bench/flash_dev_model.sv
// x16 flash model: command decode, toggle status, id and query reads
// assumes registered host strobes; stuck holds the part busy
`timescale 1ns/10ps
module flash_dev_model
    import flash_host_pkg::*;
#(
    // id values are arbitrary
    parameter logic [15:0] MFR_CODE = 16'h00A7,
    parameter logic [15:0] DEV_CODE = 16'h0B3C,
    parameter logic [15:0] EXT_CODE = 16'h0042,
    parameter bit BYTE_MODE = 1'b0,
    parameter int PROG_CYC = 40,
    parameter int ERASE_CYC = 80
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic stuck,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    output logic [DATA_W-1:0] dq_in,
    output logic [ADDR_W-1:0] last_waddr,
    output logic [DATA_W-1:0] last_wdata
);
    logic [19:0] h1, h2, key;
    logic [1:0] mode;
    logic arm_prog, arm_erase, tog, oe_prev, we_prev;
    logic [15:0] rd, last_q;
    int busy;

    function automatic logic [15:0] table_rd(logic [20:0] a);
        if (mode == 2'd1)
            return a == 21'h3 ? EXT_CODE : a == 21'h1 ? DEV_CODE : MFR_CODE;
        if (mode == 2'd2) begin
            case (BYTE_MODE ? a[8:1] : a[7:0])
                8'h10: return 16'h0051;
                8'h11: return 16'h0052;
                8'h12: return 16'h0059;
                8'h21: return 16'h0009;
                8'h22: return 16'h000F;
                8'h2A: return 16'h0002;
                default: return 16'h0000;
            endcase
        end
        return a[15:0] ^ 16'hA5C3;
    endfunction

    always_comb rd = (busy > 0 || stuck) ? {9'h000, tog, 6'h00} : table_rd(addr);
    // a released bus shows the inverse of its last value
    assign dq_in = (!oe_n && !ce_n) ? rd : ~last_q;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode <= 2'd0;
            {arm_prog, arm_erase, tog, oe_prev, we_prev} <= 5'b00011;
            {h1, h2, last_q} <= '0;
            {last_waddr, last_wdata} <= '0;
            busy <= 0;
        end else begin
            oe_prev <= oe_n;
            we_prev <= we_n;
            if (busy > 0)
                busy <= busy - 1;
            if (!oe_n && !ce_n)
                last_q <= rd;
            if (!we_n && !ce_n) begin
                last_waddr <= addr;
                last_wdata <= dq_out;
            end
            if (we_n && !we_prev) begin
                key = {last_waddr[11:0], last_wdata[7:0]};
                if (arm_prog) begin
                    busy <= PROG_CYC;
                    arm_prog <= 1'b0;
                end else if (h2 == {UNLOCK_ADDR_1, UNLOCK_DATA_1}
                             && h1 == {UNLOCK_ADDR_2, UNLOCK_DATA_2}) begin
                    case (key[7:0])
                        CMD_PROGRAM, CMD_DUAL_PROGRAM: arm_prog <= 1'b1;
                        CMD_ERASE_SETUP: arm_erase <= 1'b1;
                        CMD_CHIP_ERASE, CMD_SECTOR_ERASE: begin
                            busy <= arm_erase ? ERASE_CYC : 0;
                            arm_erase <= 1'b0;
                        end
                        CMD_ID_ENTRY: mode <= 2'd1;
                        CMD_QUERY: mode <= 2'd2;
                        default: ;
                    endcase
                end
                if (key[7:0] == CMD_ID_EXIT)
                    mode <= 2'd0;
                h2 <= h1;
                h1 <= key;
            end
            if (!oe_n && oe_prev && (busy > 0 || stuck))
                tog <= ~tog;
        end
    end
endmodule

// File: bench/flash_host_ctrl_checker.sv
// assertions on the pins and handshake of the flash host controller
// assumes binding into flash_host_ctrl; sees only its ports
`timescale 1ns/10ps
module flash_host_ctrl_checker
    import flash_host_pkg::*;
#(
    parameter longint unsigned PROGRAM_TIMEOUT = WORD_PROGRAM_CYC,
    parameter longint unsigned DUAL_TIMEOUT = DUAL_PROGRAM_CYC,
    parameter longint unsigned SMALL_ERASE_TIMEOUT = SMALL_ERASE_CYC,
    parameter longint unsigned LARGE_ERASE_TIMEOUT = LARGE_ERASE_CYC,
    parameter longint unsigned CHIP_ERASE_TIMEOUT = CHIP_ERASE_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req_valid,
    input req_s req,
    input logic req_ready,
    input logic resp_valid,
    input resp_s resp,
    input logic [ADDR_W-1:0] flash_addr,
    input logic [DATA_W-1:0] flash_dq_out,
    input logic flash_dq_oe,
    input wire logic [DATA_W-1:0] flash_dq_in,
    input logic flash_ce_n,
    input logic flash_oe_n,
    input logic flash_we_n
);
    // loose on purpose: every op plus the command cycles
    localparam longint unsigned MAX_BUSY = PROGRAM_TIMEOUT + DUAL_TIMEOUT
        + SMALL_ERASE_TIMEOUT + LARGE_ERASE_TIMEOUT + CHIP_ERASE_TIMEOUT + 64;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic [63:0] busy_q, busy_d;
    logic [ADDR_W-1:0] pa_q, pa_d, wa_q, wa_d, oa_q, oa_d;
    logic [7:0] wd_q, wd_d;
    logic ps_q, ps_d;
    logic [2:0] op_q, op_d;

    always_comb begin
        busy_d = req_ready ? 64'h0 : busy_q + 64'h1;
        {pa_d, ps_d, wa_d, wd_d, oa_d, op_d} = {pa_q, ps_q, wa_q, wd_q, oa_q, op_q};
        if (req_ready)
            ps_d = 1'b0;
        else if (!flash_oe_n)
            {ps_d, pa_d} = {1'b1, flash_addr};
        if (!flash_we_n)
            {wa_d, wd_d} = {flash_addr, flash_dq_out[7:0]};
        if (req_valid && req_ready)
            {oa_d, op_d} = {req.addr, req.op};
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            {busy_q, pa_q, ps_q, wa_q, wd_q, oa_q, op_q} <= '0;
        else
            {busy_q, pa_q, ps_q, wa_q, wd_q, oa_q, op_q} <=
                {busy_d, pa_d, ps_d, wa_d, wd_d, oa_d, op_d};
    end

    sequence s_wpulse;
        !flash_we_n [*2] ##1 flash_we_n;
    endsequence
    sequence s_rpulse;
        (!flash_oe_n && !flash_ce_n) [*2] ##1 (flash_oe_n && flash_ce_n);
    endsequence

    property p_wr_oe_high;
        !flash_we_n |-> flash_oe_n && !flash_ce_n && flash_dq_oe;
    endproperty
    a_wr_oe_high: assert property (p_wr_oe_high) else $error("oe low during a write");
    property p_wr_len;
        $fell(flash_we_n) |-> s_wpulse;
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write strobe length wrong");
    property p_rd_len;
        $fell(flash_oe_n) |-> s_rpulse;
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("read pulse not on ce and oe");
    property p_oe_gap;
        $rose(flash_oe_n) |=> flash_oe_n;
    endproperty
    a_oe_gap: assert property (p_oe_gap) else $error("oe high pulse too short");
    property p_poll_addr;
        $fell(flash_oe_n) && ps_q |-> flash_addr == pa_q;
    endproperty
    a_poll_addr: assert property (p_poll_addr) else $error("poll address moved");
    property p_no_contend;
        !flash_oe_n |-> !flash_dq_oe;
    endproperty
    a_no_contend: assert property (p_no_contend) else $error("dq driven during read");
    property p_busy_bound;
        busy_q <= MAX_BUSY;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("request never ends");
    property p_resp_idle;
        resp_valid |-> flash_ce_n && flash_oe_n && flash_we_n ##1 req_ready;
    endproperty
    a_resp_idle: assert property (p_resp_idle) else $error("answer before bus idle");
    property p_erase_data;
        resp_valid && op_q inside {OP_SMALL_ERASE, OP_LARGE_ERASE, OP_CHIP_ERASE}
            |-> wd_q == (op_q == OP_CHIP_ERASE ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE);
    endproperty
    a_erase_data: assert property (p_erase_data) else $error("erase final data wrong");
    property p_erase_addr;
        resp_valid && op_q inside {OP_SMALL_ERASE, OP_LARGE_ERASE, OP_CHIP_ERASE}
            |-> (op_q == OP_CHIP_ERASE ? wa_q[11:0] == UNLOCK_ADDR_1 : wa_q == oa_q);
    endproperty
    a_erase_addr: assert property (p_erase_addr) else $error("erase final address wrong");
endmodule

bind flash_host_ctrl flash_host_ctrl_checker #(
    .PROGRAM_TIMEOUT(PROGRAM_TIMEOUT), .DUAL_TIMEOUT(DUAL_TIMEOUT),
    .SMALL_ERASE_TIMEOUT(SMALL_ERASE_TIMEOUT), .LARGE_ERASE_TIMEOUT(LARGE_ERASE_TIMEOUT),
    .CHIP_ERASE_TIMEOUT(CHIP_ERASE_TIMEOUT)
) u_chk (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));

// File: bench/parallel_flash_cmd_status_query_tb_top.sv
// bench: fixed id entry, reads and exit, then random program and erase requests against the flash model
// assumes short timeouts so a stuck part times out fast
`timescale 1ns/10ps
module parallel_flash_cmd_status_query_tb_top
    import flash_host_pkg::*;
;
    localparam logic [15:0] MFR = 16'h00A7;
    localparam logic [15:0] DEV = 16'h0B3C;
    localparam logic [15:0] EXT = 16'h0042;
    logic sys_clk, rst, req_valid, req_ready, resp_valid, stuck;
    logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
    logic [ADDR_W-1:0] flash_addr, last_waddr;
    logic [DATA_W-1:0] flash_dq_out, flash_dq_in, last_wdata;
    req_s req;
    resp_s resp, got;
    logic [31:0] seed;
    int failures, samples_checked;

    flash_host_ctrl #(.PROGRAM_TIMEOUT(300), .DUAL_TIMEOUT(300), .SMALL_ERASE_TIMEOUT(500),
        .LARGE_ERASE_TIMEOUT(500), .CHIP_ERASE_TIMEOUT(500)) DUT (.sys_clk(sys_clk),
        .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp(resp), .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
        .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
    flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .EXT_CODE(EXT)) u_dev (
        .sys_clk(sys_clk), .rst(rst), .stuck(stuck), .addr(flash_addr),
        .dq_out(flash_dq_out), .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
        .dq_in(flash_dq_in), .last_waddr(last_waddr), .last_wdata(last_wdata));

    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    function automatic logic [15:0] exp_rd(logic [20:0] a);
        return a[15:0] ^ 16'hA5C3;
    endfunction
    function automatic logic [19:0] exp_last(op_e op, logic [20:0] a, logic [15:0] d);
        case (op)
            OP_CHIP_ERASE: return {UNLOCK_ADDR_1, CMD_CHIP_ERASE};
            OP_SMALL_ERASE, OP_LARGE_ERASE: return {a[11:0], CMD_SECTOR_ERASE};
            default: return {a[11:0], d[7:0]};
        endcase
    endfunction

    task automatic wrap_up();
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk16(string name, logic [15:0] exp, logic [15:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic chk1(string name, logic exp, logic seen);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", name, exp, seen);
        end
    endtask
    task automatic tick();
        @(posedge sys_clk);
        #2;
    endtask
    task automatic do_req(op_e op, logic [20:0] a, logic [15:0] d);
        int n;
        tick();
        req = '{op: op, addr: a, data: d};
        req_valid = 1'b1;
        for (n = 0; n < 2000 && req_ready !== 1'b1; n++)
            tick();
        tick();
        req_valid = 1'b0;
        for (n = 0; n < 20000 && resp_valid !== 1'b1; n++)
            tick();
        chk1("resp_valid", 1'b1, resp_valid);
        got = resp;
    endtask
    task automatic run_op(op_e op, logic [20:0] a, logic [15:0] d);
        logic [19:0] e;
        do_req(op, a, d);
        e = exp_last(op, a, d);
        chk1("timeout", 1'b0, got.timeout);
        chk16("final_addr", 16'(e[19:8]), 16'(last_waddr[11:0]));
        chk16("final_data", 16'(e[7:0]), 16'(last_wdata[7:0]));
        chk16("poll_data", exp_rd(a), got.rdata);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #2000000;
        failures++;
        wrap_up();
    end
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        stuck = 1'b0;
        seed = 32'h3A36;
        repeat (12) @(posedge sys_clk);
        #2;
        rst = 1'b0;
        do_req(OP_ID_ENTRY, 21'h0, 16'h0);
        do_req(OP_READ, 21'h0, 16'h0);
        chk16("maker_code", MFR, got.rdata);
        do_req(OP_READ, 21'h1, 16'h0);
        chk16("device_code", DEV, got.rdata);
        do_req(OP_READ, 21'h3, 16'h0);
        chk16("extra_code", EXT, got.rdata);
        do_req(OP_ID_EXIT, 21'h0, 16'h0);
        seed = lfsr(seed);
        do_req(OP_READ, seed[20:0], 16'h0);
        chk16("read_after_exit", exp_rd(seed[20:0]), got.rdata);
        run_op(OP_PROGRAM, 21'h0, 16'hFFFF);
        run_op(OP_DUAL_PROGRAM, 21'h1FFFFF, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            for (int op = OP_PROGRAM; op <= OP_CHIP_ERASE; op++) begin
                seed = lfsr(seed);
                run_op(op_e'(op), seed[20:0], seed[31:16]);
            end
        end
        stuck = 1'b1;
        do_req(OP_PROGRAM, 21'h00123, 16'h5A5A);
        chk1("stuck_timeout", 1'b1, got.timeout);
        stuck = 1'b0;
        run_op(OP_SMALL_ERASE, 21'h00123, 16'h0);
        wrap_up();
    end
endmodule
